// >>> logic/gtpg_cfg.svh
// Purpose: Constants for the transmit test-pattern generator.
// Assumes: ref_clk at 25 MHz, 125 MHz symbol rate reached by a symbol enable.
// Notes:   Register offsets are byte addresses on APB.
`ifndef GTPG_CFG_SVH
`define GTPG_CFG_SVH

`define GTPG_CLK_PERIOD_NS    40
`define GTPG_SYMBOL_NS        8
`define GTPG_SYM_DIV          ((`GTPG_CLK_PERIOD_NS < `GTPG_SYMBOL_NS) ? 1 : 1)
`define GTPG_CTRL_OFF         12'h000
`define GTPG_STAT_OFF         12'h004
`define GTPG_LFSR_OFF         12'h008
`define GTPG_MODE_LSB         0
`define GTPG_CLKEN_BIT        4
`define GTPG_CTRL_RESET       32'h0000_0000
`define GTPG_LFSR_SEED        11'h7ff
`define GTPG_SYM_POS2         3'h2
`define GTPG_SYM_NEG2         3'h6
`define GTPG_FIFO_DEPTH       8

`endif

// >>> logic/gtpg_pkg.sv
// Purpose: Types for the transmit test-pattern generator.
// Assumes: Nothing beyond the constants header.
// Notes:   Mode codes are one-hot.
package gtpg_pkg;
  typedef enum logic [3:0] {
    GTPG_NORMAL = 4'b0001,
    GTPG_MODE2  = 4'b0010,
    GTPG_MODE3  = 4'b0100,
    GTPG_MODE4  = 4'b1000
  } gtpg_mode_e;
  typedef logic [2:0] gtpg_sym_t;
endpackage : gtpg_pkg

// >>> logic/gtpg_fifo.sv
// Purpose: Small flip-flop FIFO with valid and ready on both sides.
// Assumes: One clock, synchronous reset.
// Notes:   Full and empty are exact.
module gtpg_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_r];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : gtpg_fifo

// >>> logic/gtpg_top.sv
// Purpose: Transmit test-pattern generator for a four-pair twisted-pair PHY.
// Assumes: ref_clk is the symbol-domain clock; sym_en marks each symbol period.
// Notes:   Symbols are 3-bit two's complement levels -2..+2.
// What this block does
// - Mode 2 times symbols from the local reference; master timing selected.
// - Mode 3 sends +2, -2 repeatedly on all four channels.
// - Mode 3 times symbols from the recovered clock; slave timing selected.
// - Mode 4 sends symbols from a maximum-length scrambler generator.
// - Mode 4 forms three bits from scrambler taps, maps them to a level.
// - Mode 4 advances the shift register once per symbol period.
// - Mode 4 presents the same symbol to all four transmitters.
// - Mode 4 times symbols from the local reference; master timing selected.
// - The transmit symbol clock is observable on an output.
// - A control bit forces the transmit symbol clock output on.
// - Mode 2 sends +2, -2 repeatedly on all four channels.
// - Test modes change the symbols fed to the transmitter; mode 3 also selects slave timing.
//
// Added by the designer: the register addresses and register access over APB.
`include "gtpg_cfg.svh"

module gtpg_top (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        sym_en,
  input  wire logic        tx_clk_in,
  input  wire logic        tclk_out_default_en,
  input  wire logic [2:0]  normal_sym_a,
  input  wire logic [2:0]  normal_sym_b,
  input  wire logic [2:0]  normal_sym_c,
  input  wire logic [2:0]  normal_sym_d,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [2:0]  tx_sym_a,
  output logic      [2:0]  tx_sym_b,
  output logic      [2:0]  tx_sym_c,
  output logic      [2:0]  tx_sym_d,
  output logic             tx_sym_valid,
  output logic             timing_master,
  output logic             transmit_symbol_clock_out
);
  // ==========================================================================
  // Register interface.
  logic [3:0]            mode_req_r;
  logic                  clk_force_r;
  gtpg_pkg::gtpg_mode_e  mode_r;
  logic [10:0]           lfsr_r;
  logic                  phase_r;
  logic                  apb_wr;
  logic                  apb_rd;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  gtpg_pkg::gtpg_sym_t   fifo_out;
  gtpg_pkg::gtpg_sym_t   test_sym;
  logic                  sym_step;
  logic [2:0]            tclk_sync_r;
  logic                  tclk_stable_r;
  gtpg_pkg::gtpg_mode_e  mode_nxt;
  logic                  phase_use;
  logic                  push_req;
  logic                  push_sym;
  gtpg_pkg::gtpg_sym_t   last_sym_r;

  assign apb_wr  = psel && penable && pwrite;
  // Read data is captured in the setup cycle, so it already stands at the access edge.
  assign apb_rd  = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr != `GTPG_CTRL_OFF) && (paddr != `GTPG_STAT_OFF)
                   && (paddr != `GTPG_LFSR_OFF);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_req_r  <= 4'h0;
      clk_force_r <= 1'b0;
    end else if (apb_wr && paddr == `GTPG_CTRL_OFF) begin
      mode_req_r  <= pwdata[`GTPG_MODE_LSB +: 4];
      clk_force_r <= pwdata[`GTPG_CLKEN_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      unique case (paddr)
        `GTPG_CTRL_OFF: prdata <= {27'h000_0000, clk_force_r, mode_req_r};
        `GTPG_STAT_OFF: prdata <= {26'h000_0000, fifo_out_valid, timing_master, mode_r};
        `GTPG_LFSR_OFF: prdata <= {21'h00_0000, lfsr_r};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Mode switching at symbol boundaries.
  function automatic gtpg_pkg::gtpg_mode_e decode_mode(input logic [3:0] req);
    unique case (req)
      4'h2:    decode_mode = gtpg_pkg::GTPG_MODE2;
      4'h3:    decode_mode = gtpg_pkg::GTPG_MODE3;
      4'h4:    decode_mode = gtpg_pkg::GTPG_MODE4;
      default: decode_mode = gtpg_pkg::GTPG_NORMAL;
    endcase
  endfunction : decode_mode

  assign sym_step = sym_en && fifo_in_ready;
  // A symbol taken at a boundary already belongs to the mode that starts there, so source and
  // timing change on the same edge; normal traffic bypasses the buffer.
  assign mode_nxt = decode_mode(mode_req_r);
  assign push_req = sym_en && (mode_nxt != gtpg_pkg::GTPG_NORMAL);
  assign push_sym = push_req && fifo_in_ready;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_r <= gtpg_pkg::GTPG_NORMAL;
    end else if (sym_step) begin
      mode_r <= decode_mode(mode_req_r);
    end
  end

  // Master in mode 2 and 4, slave in mode 3; normal traffic also selects master.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timing_master <= 1'b1;
    end else if (sym_step) begin
      unique case (decode_mode(mode_req_r))
        gtpg_pkg::GTPG_MODE2:  timing_master <= 1'b1;
        gtpg_pkg::GTPG_MODE3:  timing_master <= 1'b0;
        gtpg_pkg::GTPG_MODE4:  timing_master <= 1'b1;
        gtpg_pkg::GTPG_NORMAL: timing_master <= 1'b1;
      endcase
    end
  end

  // ==========================================================================
  // Pattern sources.
  // The alternation restarts at +2 whenever a pattern mode is entered.
  assign phase_use = (mode_nxt == mode_r) && phase_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_r <= 1'b0;
    end else if (push_sym) begin
      phase_r <= ~phase_use;
    end
  end

  // 11-bit maximal-length register, one step per mode 4 symbol.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lfsr_r <= `GTPG_LFSR_SEED;
    end else if (push_sym && mode_nxt == gtpg_pkg::GTPG_MODE4) begin
      lfsr_r <= {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[8]};
    end
  end

  function automatic gtpg_pkg::gtpg_sym_t map_sym(input logic [2:0] x);
    unique case (x)
      3'h0:    map_sym = 3'h0;
      3'h1:    map_sym = 3'h1;
      3'h2:    map_sym = 3'h2;
      3'h3:    map_sym = 3'h7;
      3'h4:    map_sym = 3'h6;
      3'h5:    map_sym = 3'h0;
      3'h6:    map_sym = 3'h1;
      default: map_sym = 3'h7;
    endcase
  endfunction : map_sym

  logic scrambler_derived_bit_a;
  logic scrambler_derived_bit_b;
  logic scrambler_derived_bit_c;
  assign scrambler_derived_bit_a = lfsr_r[0];
  assign scrambler_derived_bit_b = lfsr_r[1] ^ lfsr_r[4];
  assign scrambler_derived_bit_c = lfsr_r[2] ^ lfsr_r[7];

  always_comb begin
    unique case (mode_nxt)
      gtpg_pkg::GTPG_MODE2,
      gtpg_pkg::GTPG_MODE3: test_sym = phase_use ? `GTPG_SYM_NEG2 : `GTPG_SYM_POS2;
      gtpg_pkg::GTPG_MODE4: test_sym = map_sym({scrambler_derived_bit_c, scrambler_derived_bit_b,
                                                scrambler_derived_bit_a});
      default:              test_sym = normal_sym_a;
    endcase
  end

  // ==========================================================================
  // Symbol buffer and output stage; test symbols share one lane.
  gtpg_fifo #(
    .WIDTH (3),
    .DEPTH (`GTPG_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .in_valid  (push_req),
    .in_ready  (fifo_in_ready),
    .in_data   (test_sym),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_sym_a     <= 3'h0;
      tx_sym_b     <= 3'h0;
      tx_sym_c     <= 3'h0;
      tx_sym_d     <= 3'h0;
      tx_sym_valid <= 1'b0;
    end else begin
      tx_sym_valid <= fifo_out_valid;
      if (mode_r == gtpg_pkg::GTPG_NORMAL) begin
        tx_sym_a <= normal_sym_a;
        tx_sym_b <= normal_sym_b;
        tx_sym_c <= normal_sym_c;
        tx_sym_d <= normal_sym_d;
      end else if (fifo_out_valid) begin
        tx_sym_a <= fifo_out;
        tx_sym_b <= fifo_out;
        tx_sym_c <= fifo_out;
        tx_sym_d <= fifo_out;
      end
    end
  end

  // ==========================================================================
  // Symbol clock observation: three-stage sampler, agreement of stages two and three.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tclk_sync_r   <= 3'h0;
      tclk_stable_r <= 1'b0;
    end else begin
      tclk_sync_r <= {tclk_sync_r[1:0], tx_clk_in};
      if (tclk_sync_r[2] == tclk_sync_r[1]) begin
        tclk_stable_r <= tclk_sync_r[2];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      transmit_symbol_clock_out <= 1'b0;
    end else begin
      transmit_symbol_clock_out <= (clk_force_r || tclk_out_default_en) && tclk_stable_r;
    end
  end

  // ==========================================================================
  // Checks.
  mode_sync_a: assert property (@(posedge ref_clk) disable iff (srst)
    !sym_step |=> $stable(mode_r)) else $error("mode changed off a symbol boundary");
  slave_mode3_a: assert property (@(posedge ref_clk) disable iff (srst)
    mode_r == gtpg_pkg::GTPG_MODE3 |-> !timing_master) else $error("mode 3 not slave");
  master_mode24_a: assert property (@(posedge ref_clk) disable iff (srst)
    (mode_r == gtpg_pkg::GTPG_MODE2 || mode_r == gtpg_pkg::GTPG_MODE4) |-> timing_master)
    else $error("mode 2 or 4 not master");
  lfsr_step_a: assert property (@(posedge ref_clk) disable iff (srst)
    !sym_step |=> $stable(lfsr_r)) else $error("scrambler moved without a symbol");
  lanes_equal_a: assert property (@(posedge ref_clk) disable iff (srst)
    $past(mode_r) != gtpg_pkg::GTPG_NORMAL && $past(fifo_out_valid) |->
    tx_sym_a == tx_sym_b && tx_sym_c == tx_sym_d && tx_sym_a == tx_sym_c)
    else $error("lanes differ in test mode");
  alt_pattern_a: assert property (@(posedge ref_clk) disable iff (srst)
    push_sym && mode_nxt == gtpg_pkg::GTPG_MODE3 |-> test_sym == `GTPG_SYM_POS2 || test_sym == `GTPG_SYM_NEG2)
    else $error("bad alternating symbol");
  normal_pass_a: assert property (@(posedge ref_clk) disable iff (srst)
    mode_r == gtpg_pkg::GTPG_NORMAL |=> tx_sym_d == $past(normal_sym_d))
    else $error("normal traffic altered");
  clk_off_a: assert property (@(posedge ref_clk) disable iff (srst)
    !clk_force_r && !tclk_out_default_en |=> !transmit_symbol_clock_out)
    else $error("symbol clock out while disabled");

  // ==========================================================================
  // Pattern, timing and bus checks.
  // Last test symbol taken, for the alternation checks below.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      last_sym_r <= 3'h0;
    end else if (push_sym) begin
      last_sym_r <= test_sym;
    end
  end

  alt_mode2_a: assert property (@(posedge ref_clk) disable iff (srst)
    push_sym && mode_nxt == gtpg_pkg::GTPG_MODE2 |-> test_sym == `GTPG_SYM_POS2 || test_sym == `GTPG_SYM_NEG2)
    else $error("bad mode 2 symbol");
  alt_swap2_a: assert property (@(posedge ref_clk) disable iff (srst)
    push_sym && mode_nxt == gtpg_pkg::GTPG_MODE2 && mode_r == gtpg_pkg::GTPG_MODE2 |-> test_sym != last_sym_r)
    else $error("mode 2 pattern did not alternate");
  alt_swap3_a: assert property (@(posedge ref_clk) disable iff (srst)
    push_sym && mode_nxt == gtpg_pkg::GTPG_MODE3 && mode_r == gtpg_pkg::GTPG_MODE3 |-> test_sym != last_sym_r)
    else $error("mode 3 pattern did not alternate");
  alt_start_a: assert property (@(posedge ref_clk) disable iff (srst)
    push_sym && mode_nxt != mode_r && (mode_nxt == gtpg_pkg::GTPG_MODE2 || mode_nxt == gtpg_pkg::GTPG_MODE3)
    |-> test_sym == `GTPG_SYM_POS2) else $error("alternation did not start at +2");
  scr_level_a: assert property (@(posedge ref_clk) disable iff (srst)
    push_sym && mode_nxt == gtpg_pkg::GTPG_MODE4 |-> test_sym inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7})
    else $error("scrambler symbol off the five levels");
  lfsr_moves_a: assert property (@(posedge ref_clk) disable iff (srst)
    push_sym && mode_nxt == gtpg_pkg::GTPG_MODE4 |=> lfsr_r != $past(lfsr_r))
    else $error("scrambler did not step with a symbol");
  lfsr_live_a: assert property (@(posedge ref_clk) disable iff (srst)
    lfsr_r != 11'h000) else $error("scrambler locked at zero");
  lfsr_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
    mode_nxt != gtpg_pkg::GTPG_MODE4 |=> $stable(lfsr_r))
    else $error("scrambler moved outside mode 4");
  master_step_a: assert property (@(posedge ref_clk) disable iff (srst)
    sym_step && mode_nxt == gtpg_pkg::GTPG_MODE2 |=> timing_master)
    else $error("mode 2 entry not master");
  slave_step_a: assert property (@(posedge ref_clk) disable iff (srst)
    sym_step && mode_nxt == gtpg_pkg::GTPG_MODE3 |=> !timing_master)
    else $error("mode 3 entry not slave");
  master_mode4_a: assert property (@(posedge ref_clk) disable iff (srst)
    mode_r == gtpg_pkg::GTPG_MODE4 |-> timing_master)
    else $error("mode 4 not master");
  tclk_force_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_force_r && tclk_stable_r |=> transmit_symbol_clock_out)
    else $error("forced symbol clock missing");
  tclk_follow_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_force_r || tclk_out_default_en |=> transmit_symbol_clock_out == $past(tclk_stable_r))
    else $error("symbol clock out does not follow the clock");
  normal_lanes_a: assert property (@(posedge ref_clk) disable iff (srst)
    mode_r == gtpg_pkg::GTPG_NORMAL |=> tx_sym_a == $past(normal_sym_a) && tx_sym_b == $past(normal_sym_b)
    && tx_sym_c == $past(normal_sym_c))
    else $error("normal traffic altered on a lane");
  test_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    mode_r != gtpg_pkg::GTPG_NORMAL && !fifo_out_valid |=> $stable(tx_sym_a) && $stable(tx_sym_d))
    else $error("test symbol changed without a new symbol");
  ctrl_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    psel && penable && pwrite && paddr == `GTPG_CTRL_OFF |=> {28'h000_0000, mode_req_r} == ($past(pwdata) & 32'h0000_000f))
    else $error("mode select write lost");
  bad_addr_a: assert property (@(posedge ref_clk) disable iff (srst)
    psel && penable && pslverr |=> $stable(mode_req_r) && $stable(clk_force_r))
    else $error("refused write changed control");
  pslverr_map_a: assert property (@(posedge ref_clk) disable iff (srst)
    psel && penable && paddr == `GTPG_CTRL_OFF |-> !pslverr)
    else $error("control access refused");
  sym_room_a: assert property (@(posedge ref_clk) disable iff (srst)
    sym_en |-> fifo_in_ready) else $error("symbol refused by the buffer");
endmodule : gtpg_top

// >>> tb/gtpg_line_eq.sv
// Purpose: Line equipment model at the far side of the pattern generator.
// Assumes: The recovered symbol clock runs free, as on a live link.
// Notes:   Counts the test symbols that reach the four pairs.
module gtpg_line_eq (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        tx_sym_valid,
  output logic             tx_clk_in,
  output logic      [15:0] rx_cnt
);
  logic [1:0] div_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_r  <= 2'h0;
      rx_cnt <= 16'h0000;
    end else begin
      div_r <= div_r + 2'h1;
      if (tx_sym_valid) rx_cnt <= rx_cnt + 16'h0001;
    end
  end
  assign tx_clk_in = div_r[1];
endmodule : gtpg_line_eq

// >>> tb/tb.sv
// Purpose: Self-checking bench for the test-pattern generator.
// Assumes: Read data stands at the access edge, so each read is one transfer.
// Notes:   Symbols are collected whenever tx_sym_valid is high.
`include "gtpg_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, srst, sym_en, tclk_out_default_en, psel, penable, pwrite;
  logic        pready, pslverr, tx_sym_valid, timing_master, transmit_symbol_clock_out, tx_clk_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  tx_sym_a, tx_sym_b, tx_sym_c, tx_sym_d, ns_a, ns_b, ns_c, ns_d;
  logic [15:0] rx_cnt;
  logic [3:0]  q[$];
  int          errors, checks_done;
  gtpg_top i_dut (.ref_clk(ref_clk), .srst(srst), .sym_en(sym_en), .tx_clk_in(tx_clk_in),
    .tclk_out_default_en(tclk_out_default_en), .normal_sym_a(ns_a), .normal_sym_b(ns_b),
    .normal_sym_c(ns_c), .normal_sym_d(ns_d), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_sym_a(tx_sym_a), .tx_sym_b(tx_sym_b), .tx_sym_c(tx_sym_c), .tx_sym_d(tx_sym_d),
    .tx_sym_valid(tx_sym_valid), .timing_master(timing_master),
    .transmit_symbol_clock_out(transmit_symbol_clock_out));
  gtpg_line_eq i_line (.ref_clk(ref_clk), .srst(srst), .tx_sym_valid(tx_sym_valid),
    .tx_clk_in(tx_clk_in), .rx_cnt(rx_cnt));
  // ==========
  // Checking and bus tasks
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_b
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic reg_rd(input logic [11:0] a, output logic [31:0] rd, output logic err);
    apb(1'b0, a, 32'h0000_0000, rd, err);
  endtask : reg_rd
  task automatic run_mode(input logic [31:0] ctrl, input int n, input int exp_n);
    logic [31:0] rd;
    logic        e;
    logic [15:0] c0;
    apb(1'b1, `GTPG_CTRL_OFF, ctrl, rd, e);
    q.delete();
    c0 = rx_cnt;
    @(posedge ref_clk);
    sym_en <= 1'b1;
    repeat (n) @(posedge ref_clk);
    sym_en <= 1'b0;
    repeat (16) @(posedge ref_clk);
    chk_w(32'(rx_cnt - c0), 32'(exp_n));
  endtask : run_mode
  task automatic chk_q(input logic m, input logic alt);
    foreach (q[i]) begin
      chk_b(q[i][3], m);
      if (alt) chk_w(32'(q[i][2:0]), (i % 2) ? 32'(`GTPG_SYM_NEG2) : 32'(`GTPG_SYM_POS2));
      else chk_b(q[i][2:0] inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7}, 1'b1);
    end
  endtask : chk_q
  task automatic rises(input logic [31:0] ctrl, output int r);
    logic [31:0] rd;
    logic        e, p;
    apb(1'b1, `GTPG_CTRL_OFF, ctrl, rd, e);
    repeat (8) @(posedge ref_clk);
    r = 0;
    p = transmit_symbol_clock_out;
    repeat (40) begin
      @(posedge ref_clk);
      if (transmit_symbol_clock_out === 1'b1 && p !== 1'b1) r++;
      p = transmit_symbol_clock_out;
    end
  endtask : rises
  // ==========
  // Clock, lane monitor and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (srst === 1'b0 && tx_sym_valid === 1'b1) begin
      q.push_back({timing_master, tx_sym_a});
      chk_b(tx_sym_b === tx_sym_a && tx_sym_c === tx_sym_a && tx_sym_d === tx_sym_a, 1'b1);
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    final_report();
  end
  // ==========
  // Test sequence
  initial begin
    logic [31:0] rd, l0;
    logic        e;
    int          r;
    {srst, sym_en, tclk_out_default_en, psel, penable, pwrite} = 6'b100000;
    {paddr, pwdata} = '0;
    {ns_a, ns_b, ns_c, ns_d} = {3'h1, 3'h7, 3'h0, 3'h2};
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    reg_rd(`GTPG_CTRL_OFF, rd, e);
    chk_w(rd, `GTPG_CTRL_RESET);
    reg_rd(`GTPG_STAT_OFF, rd, e);
    chk_w(rd, 32'h0000_0011);
    apb(1'b1, 12'h010, 32'h0000_0013, rd, e);
    chk_b(e, 1'b1);
    reg_rd(`GTPG_CTRL_OFF, rd, e);
    chk_w(rd, `GTPG_CTRL_RESET);
    run_mode(32'h0000_0000, 4, 0);
    chk_w(32'({tx_sym_a, tx_sym_b, tx_sym_c, tx_sym_d}), 32'({ns_a, ns_b, ns_c, ns_d}));
    run_mode(32'h0000_0002, 9, 9);
    chk_q(1'b1, 1'b1);
    run_mode(32'h0000_0003, 8, 8);
    chk_q(1'b0, 1'b1);
    reg_rd(`GTPG_LFSR_OFF, l0, e);
    run_mode(32'h0000_0004, 7, 7);
    chk_q(1'b1, 1'b0);
    reg_rd(`GTPG_LFSR_OFF, rd, e);
    chk_b(rd !== l0, 1'b1);
    repeat (6) @(posedge ref_clk);
    reg_rd(`GTPG_LFSR_OFF, l0, e);
    chk_w(l0, rd);
    rises(32'h0000_0000, r);
    chk_w(32'(r), 32'h0000_0000);
    rises(32'h0000_0010, r);
    chk_b(r > 7, 1'b1);
    rises(32'h0000_0013, r);
    chk_b(r > 7, 1'b1);
    tclk_out_default_en <= 1'b1;
    rises(32'h0000_0002, r);
    chk_b(r > 7, 1'b1);
    final_report();
  end
endmodule : tb
